// ===== rtl/dtt_top.sv
// dual timebase capture timer with axi4-lite register slave
// Operation
// - hidden counter one starts at zero, steps every 32 clocks, not software visible
// - counter one counts 00h to F9h then wraps; wrap is its overflow
// - timebase event every 8000 clocks, or 16000 with period select set
// - timebase-one event sets its flag; irq when its enable is set
// - reading first control/status register clears timebase-one flag
// - writes to timebase flag positions leave the flags unchanged
// - either edge on capture pin copies counter one into capture value
// - capture sets capture flag; irq when capture enable is set
// - reading capture register clears capture flag
// - while capture flag set, edges do not update capture register
// - writes to capture flag position do not alter it
// - counter two starts at reload value, steps every 32 clocks
// - counter two wraps from FFh to reload value; that is overflow
// - new reload value takes effect only at next counter two overflow
// - counter two live value readable through read-only register
// - counter two overflow sets timebase-two flag; irq if enabled; read clears
// - both counters stop in halt, run in slow, wait, active-halt
// - three events drive three separate interrupt lines
// - reload value read/write, resets to zero
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module dtt_top #(
  parameter int PRESC_DIV = dtt_pkg::PRESC_DIV_DEF
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      ce,
  input  wire logic                      halt_mode,
  input  wire logic                      capture_input_pin,
  input  wire logic [dtt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [dtt_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [dtt_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [dtt_pkg::DATA_W-1:0]     s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic                           irq_timebase_one,
  output logic                           irq_timebase_two,
  output logic                           irq_capture
);
  import dtt_pkg::*;

  localparam int PW = $clog2(PRESC_DIV);
  localparam logic [PW-1:0] PRESC_MAX = PW'(PRESC_DIV - 1);

  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [2:0] s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[6:2])
        IDX_TB2_CSR:  s = SEL_TB2_CSR;
        IDX_RELOAD:   s = SEL_RELOAD;
        IDX_C2_VALUE: s = SEL_C2_VALUE;
        IDX_TB1_CSR:  s = SEL_TB1_CSR;
        IDX_CAPTURE:  s = SEL_CAPTURE;
        default:      s = SEL_NONE;
      endcase
    end
    if (a[ADDR_W-1] != 1'b0) begin
      s = SEL_NONE;
    end
    return s;
  endfunction

  logic [PW-1:0]     presc_ff;
  logic [7:0]        c1_ff;
  logic              half_ff;
  logic [7:0]        c2_ff;
  logic [7:0]        reload_ff;
  logic              tb1_flag_ff;
  logic              tb1_ie_ff;
  logic              period_sel_ff;
  logic              tb2_flag_ff;
  logic              tb2_ie_ff;
  logic              cap_flag_ff;
  logic              cap_ie_ff;
  logic [7:0]        cap_value_ff;
  logic              pin_s1_ff;
  logic              pin_s2_ff;
  logic              pin_prev_ff;
  logic              aw_got_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic              w_got_ff;
  logic [7:0]        wdata_ff;
  logic              wstrb0_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [1:0]        rresp_ff;

  logic       tick;
  logic       c1_ovf;
  logic       tb1_evt;
  logic       c2_ovf;
  logic       cap_edge;
  logic       cap_evt;
  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;
  logic       do_wr;
  logic [2:0] wsel;
  logic [2:0] rsel;
  logic       rd_tb1_csr;
  logic       rd_tb2_csr;
  logic       rd_capture;
  logic [7:0] rbyte;

  // halt freezes only the divided clock; slow, wait and active-halt do not reach here
  assign tick     = ce && !halt_mode && (presc_ff == PRESC_MAX);
  assign c1_ovf   = tick && (c1_ff == C1_TOP);
  assign tb1_evt  = c1_ovf && (!period_sel_ff || half_ff);
  assign c2_ovf   = tick && (c2_ff == C2_TOP);
  assign cap_edge = pin_s2_ff ^ pin_prev_ff;
  assign cap_evt  = ce && cap_edge && !cap_flag_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_ff <= '0;
    end else if (ce && !halt_mode) begin
      presc_ff <= (presc_ff == PRESC_MAX) ? '0 : presc_ff + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c1_ff <= ZERO8;
    end else if (tick) begin
      c1_ff <= (c1_ff == C1_TOP) ? ZERO8 : c1_ff + 8'h01;
    end
  end

  // second overflow marks the event when the doubled period is chosen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_ff <= 1'b0;
    end else if (ce && !period_sel_ff) begin
      half_ff <= 1'b0;
    end else if (c1_ovf) begin
      half_ff <= !half_ff;
    end
  end

  // reload only sampled at the wrap, so a write mid-period waits for it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c2_ff <= RELOAD_RST;
    end else if (tick) begin
      c2_ff <= (c2_ff == C2_TOP) ? reload_ff : c2_ff + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_ff   <= capture_input_pin;
      pin_s2_ff   <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff; // follows the pin so release brings no false edge
    end else if (ce) begin
      pin_s1_ff   <= capture_input_pin;
      pin_s2_ff   <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_value_ff <= ZERO8;
    end else if (cap_evt) begin
      cap_value_ff <= c1_ff;
    end
  end

  // bus side
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign do_wr = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wsel  = reg_sel(awaddr_ff);
  assign rsel  = reg_sel(s_axi_araddr);

  assign rd_tb1_csr = ar_hs && (rsel == SEL_TB1_CSR);
  assign rd_tb2_csr = ar_hs && (rsel == SEL_TB2_CSR);
  assign rd_capture = ar_hs && (rsel == SEL_CAPTURE);

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready  = !w_got_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (aw_hs) begin
      aw_got_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_ff  <= 1'b0;
      wdata_ff  <= ZERO8;
      wstrb0_ff <= 1'b0;
    end else if (w_hs) begin
      w_got_ff  <= 1'b1;
      wdata_ff  <= s_axi_wdata[7:0];
      wstrb0_ff <= s_axi_wstrb[0];
    end else if (do_wr) begin
      w_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // flag bits are not in any write path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_ff     <= RELOAD_RST;
      tb2_ie_ff     <= 1'b0;
      tb1_ie_ff     <= 1'b0;
      period_sel_ff <= 1'b0;
      cap_ie_ff     <= 1'b0;
    end else if (do_wr && wstrb0_ff) begin
      case (wsel)
        SEL_RELOAD:  reload_ff <= wdata_ff;
        SEL_TB2_CSR: tb2_ie_ff <= wdata_ff[B_TB2_IE];
        SEL_TB1_CSR: begin
          tb1_ie_ff     <= wdata_ff[B_TB1_IE];
          period_sel_ff <= wdata_ff[B_PERIOD_SEL];
          cap_ie_ff     <= wdata_ff[B_CAP_IE];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tb1_flag_ff <= 1'b0;
    end else if (tb1_evt) begin
      tb1_flag_ff <= 1'b1;
    end else if (rd_tb1_csr) begin
      tb1_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tb2_flag_ff <= 1'b0;
    end else if (c2_ovf) begin
      tb2_flag_ff <= 1'b1;
    end else if (rd_tb2_csr) begin
      tb2_flag_ff <= 1'b0;
    end
  end

  // reset value is defined here, yet software still clears it by a read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_flag_ff <= 1'b0;
    end else if (cap_evt) begin
      cap_flag_ff <= 1'b1;
    end else if (rd_capture) begin
      cap_flag_ff <= 1'b0;
    end
  end

  always_comb begin
    case (rsel)
      SEL_TB2_CSR: begin
        rbyte = ZERO8;
        rbyte[B_TB2_FLAG] = tb2_flag_ff;
        rbyte[B_TB2_IE]   = tb2_ie_ff;
      end
      SEL_RELOAD:   rbyte = reload_ff;
      SEL_C2_VALUE: rbyte = c2_ff;
      SEL_TB1_CSR: begin
        rbyte = ZERO8;
        rbyte[B_TB1_FLAG]   = tb1_flag_ff;
        rbyte[B_TB1_IE]     = tb1_ie_ff;
        rbyte[B_PERIOD_SEL] = period_sel_ff;
        rbyte[B_CAP_FLAG]   = cap_flag_ff;
        rbyte[B_CAP_IE]     = cap_ie_ff;
      end
      SEL_CAPTURE:  rbyte = cap_value_ff;
      default:      rbyte = ZERO8;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {{(DATA_W-8){1'b0}}, rbyte};
      rresp_ff  <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign irq_timebase_one = tb1_flag_ff && tb1_ie_ff;
  assign irq_timebase_two = tb2_flag_ff && tb2_ie_ff;
  assign irq_capture      = cap_flag_ff && cap_ie_ff;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_c1_last;
    tick && (c1_ff == C1_TOP);
  endsequence

  sequence s_accept_edge;
    cap_evt ##0 (1'b1);
  endsequence

  property p_c1_wrap;
    s_c1_last |=> (c1_ff == ZERO8);
  endproperty
  a_c1_wrap: assert property (p_c1_wrap) else $error("counter one wrap wrong");

  property p_c1_still;
    !tick |=> $stable(c1_ff) && $stable(c2_ff);
  endproperty
  a_c1_still: assert property (p_c1_still) else $error("counter moved off tick");

  property p_double;
    tb1_evt && period_sel_ff |-> half_ff;
  endproperty
  a_double: assert property (p_double) else $error("doubled period event early");

  property p_tb1_irq;
    tb1_evt && tb1_ie_ff |=> irq_timebase_one && tb1_flag_ff;
  endproperty
  a_tb1_irq: assert property (p_tb1_irq) else $error("timebase one irq missing");

  property p_tb1_clear;
    rd_tb1_csr && !tb1_evt |=> !tb1_flag_ff && s_axi_rvalid;
  endproperty
  a_tb1_clear: assert property (p_tb1_clear) else $error("tb1 read clear failed");

  property p_cap_copy;
    s_accept_edge |=> cap_flag_ff && (cap_value_ff == $past(c1_ff));
  endproperty
  a_cap_copy: assert property (p_cap_copy) else $error("capture value wrong");

  property p_cap_hold;
    cap_flag_ff |=> $stable(cap_value_ff);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture changed while flagged");

  property p_c2_reload;
    tick && (c2_ff == C2_TOP) |=> (c2_ff == $past(reload_ff)) && tb2_flag_ff;
  endproperty
  a_c2_reload: assert property (p_c2_reload) else $error("counter two reload wrong");

  property p_halt;
    halt_mode [*2] |=> $stable(c1_ff) && $stable(c2_ff) && $stable(presc_ff);
  endproperty
  a_halt: assert property (p_halt) else $error("counters ran in halt");

  property p_set_wins;
    rd_capture && cap_evt |=> cap_flag_ff;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("capture flag event lost");

endmodule // dtt_top

// ===== rtl/dtt_pkg.sv
// constants shared by the dual timebase capture timer
package dtt_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          PRESC_DIV_DEF = 32;
  // register indices; byte address is four times the index
  localparam logic [4:0]  IDX_TB2_CSR   = 5'h0C;
  localparam logic [4:0]  IDX_RELOAD    = 5'h0D;
  localparam logic [4:0]  IDX_C2_VALUE  = 5'h0E;
  localparam logic [4:0]  IDX_TB1_CSR   = 5'h0F;
  localparam logic [4:0]  IDX_CAPTURE   = 5'h10;
  // register select codes
  localparam logic [2:0]  SEL_NONE      = 3'h0;
  localparam logic [2:0]  SEL_TB2_CSR   = 3'h1;
  localparam logic [2:0]  SEL_RELOAD    = 3'h2;
  localparam logic [2:0]  SEL_C2_VALUE  = 3'h3;
  localparam logic [2:0]  SEL_TB1_CSR   = 3'h4;
  localparam logic [2:0]  SEL_CAPTURE   = 3'h5;
  // field positions in timebase2_ctrl_status
  localparam int          B_TB2_FLAG    = 0;
  localparam int          B_TB2_IE      = 1;
  // field positions in timebase1_capture_ctrl_status
  localparam int          B_TB1_FLAG    = 3;
  localparam int          B_TB1_IE      = 4;
  localparam int          B_PERIOD_SEL  = 5;
  localparam int          B_CAP_FLAG    = 6;
  localparam int          B_CAP_IE      = 7;
  // counter values and reset values
  localparam logic [7:0]  C1_TOP        = 8'hF9;
  localparam logic [7:0]  C2_TOP        = 8'hFF;
  localparam logic [7:0]  ZERO8         = 8'h00;
  localparam logic [7:0]  RELOAD_RST    = 8'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// ===== tb/test_dtt_top.sv
// self-checking bench for the dual timebase capture timer
`timescale 1ns/10ps
module test_dtt_top;
  import dtt_pkg::*;
  // short prescaler keeps the run brief; every period below scales with it
  localparam int DIV = 4;
  logic        aclk;
  logic        aresetn;
  logic        ce;
  logic        halt_mode;
  logic        pin;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic        awvalid;
  logic        awready;
  logic        wvalid;
  logic        wready;
  logic        bvalid;
  logic        bready;
  logic        arvalid;
  logic        arready;
  logic        rvalid;
  logic        rready;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [31:0] w;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [1:0]  resp;
  logic [2:0]  irqs;
  logic [3:0]  wstrb;
  logic [7:0]  ra [4] = '{8'h30, 8'h34, 8'h3C, 8'h40};
  int          err_total;
  int          check_count;
  int          cyc = 0;
  int          t0;
  int          t1;

  dtt_top #(.PRESC_DIV(DIV)) uut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .halt_mode(halt_mode),
    .capture_input_pin(pin), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq_timebase_one(irqs[0]), .irq_timebase_two(irqs[1]), .irq_capture(irqs[2])
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // each transfer starts one edge after the last so no strobe is set twice at one edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    resp = bresp;
    bready <= 1'b0;
    if (n >= 100) err_total++;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n >= 100) err_total++;
  endtask

  // bounded wait for an interrupt line; t is the cycle at which it is first seen
  task automatic wait_hi(input int k, output int t);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (irqs[k] !== 1'b1 && n < 5000);
    if (n >= 5000) err_total++;
    t = cyc;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge aclk);
    err_total++;
    close_out();
  end

  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    halt_mode = 1'b0;
    pin = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    err_total = 0;
    check_count = 0;
    wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], v);
      chk(v, 32'h0);
    end
    rd(8'h44, v);
    chk(resp, RESP_SLVERR);
    chk(v, 32'h0);
    rd(8'h31, v);
    chk(resp, RESP_SLVERR);
    wr(8'h44, 32'h55);
    chk(resp, RESP_SLVERR);
    wr(8'h40, 32'h55);
    rd(8'h40, v);
    chk(v, 32'h0);
    $display("test reset_and_map done");
    // new reload must not disturb the count already running from zero
    wr(8'h34, 32'hF0);
    // a write without byte lane zero must leave the reload alone
    wstrb <= 4'h0;
    wr(8'h34, 32'h11);
    chk(resp, RESP_OKAY);
    wstrb <= 4'hF;
    rd(8'h34, v);
    chk(v, 32'hF0);
    rd(8'h38, v);
    chk(v < 32'h10, 1'b1);
    wr(8'h30, 32'h03);
    rd(8'h30, v);
    chk(v, 32'h02);
    wait_hi(1, t0);
    rd(8'h38, v);
    chk(v >= 32'hF0 && v <= 32'hF2, 1'b1);
    rd(8'h30, v);
    chk(v, 32'h03);
    rd(8'h30, v);
    chk(v, 32'h02);
    chk(irqs[1], 1'b0);
    wait_hi(1, t0);
    rd(8'h30, v);
    wait_hi(1, t1);
    chk(t1 - t0, 16 * DIV);
    wr(8'h30, 32'h00);
    repeat (100) @(posedge aclk);
    chk(irqs[1], 1'b0);
    rd(8'h30, v);
    chk(v, 32'h01);
    $display("test counter_two done");
    wr(8'h3C, 32'h18);
    rd(8'h3C, v);
    wait_hi(0, t0);
    rd(8'h3C, v);
    chk(v, 32'h18);
    rd(8'h3C, v);
    chk(v, 32'h10);
    wait_hi(0, t1);
    chk(t1 - t0, 250 * DIV);
    wr(8'h3C, 32'h30);
    rd(8'h3C, v);
    wait_hi(0, t0);
    rd(8'h3C, v);
    chk(v, 32'h38);
    wait_hi(0, t1);
    chk(t1 - t0, 500 * DIV);
    $display("test timebase_one done");
    // capture right after a wrap, so counter one is known to be near zero
    wr(8'h3C, 32'h90);
    rd(8'h40, v);
    rd(8'h3C, v);
    wait_hi(0, t0);
    pin <= ~pin;
    wait_hi(2, t1);
    repeat (40) @(posedge aclk);
    pin <= ~pin;
    repeat (10) @(posedge aclk);
    wr(8'h3C, 32'h90);
    rd(8'h3C, v);
    chk(v & 32'h40, 32'h40);
    rd(8'h40, v);
    chk(v <= 32'h02, 1'b1);
    rd(8'h3C, v);
    chk(v & 32'h40, 32'h0);
    chk(irqs[2], 1'b0);
    $display("test capture done");
    for (int k = 0; k < 2; k++) begin
      if (k == 0) halt_mode <= 1'b1;
      else ce <= 1'b0;
      rd(8'h38, v);
      repeat (40) @(posedge aclk);
      rd(8'h38, w);
      chk(w, v);
      halt_mode <= 1'b0;
      ce <= 1'b1;
      repeat (40) @(posedge aclk);
      rd(8'h38, w);
      chk(w !== v, 1'b1);
    end
    $display("test halt done");
    close_out();
  end
endmodule // test_dtt_top
